// ---- rtl/dma_channel_event_irq.sv ----
// Module: DMA channel start/abort event selection and interrupt flags
module dma_channel_event_irq
  import dma_event_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [addr_width-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [irq_count-1:0]  irq_lines,
  input  wire logic [size_width-1:0] source_pointer,
  input  wire logic [size_width-1:0] source_size,
  input  wire logic [size_width-1:0] dest_pointer,
  input  wire logic [size_width-1:0] dest_size,
  input  wire logic [size_width-1:0] cell_count,
  input  wire logic [size_width-1:0] cell_size,
  input  wire logic [size_width-1:0] block_count,
  input  wire logic                  pattern_match,
  input  wire logic                  address_invalid,
  output logic                       start_transfer,
  output logic                       abort_transfer,
  output logic                       channel_off,
  output logic                       irq
);

  // Flag bank: sticky flags, their enables and the registered request
  flag_bank_if fb ();

  flag_bank u_flag_bank
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .fb      (fb)
  );

  // Event control word as software sees it:
  //   31:24 unused, reads zero
  //   23:16 abort request selector
  //   15:8  start request selector
  //   7     force transfer strobe, reads zero
  //   6     software abort strobe, reads zero
  //   5     pattern abort enable
  //   4     start request enable
  //   3     abort request enable
  //   2:0   unused, reads zero
  // Interrupt control word:
  //   31:24 unused, 23:16 flag enables, 15:8 unused
  //   7:0   sticky flags, write one to clear
  // Event control storage
  logic [7:0] abort_request_select;
  logic [7:0] start_request_select;
  logic       pattern_abort_enable;
  logic       start_request_enable;
  logic       abort_request_enable;

  // APB answer state
  apb_state_t apb_state;
  apb_state_t next_apb_state;

  // Previous levels for edge detection
  logic start_line_prev;
  logic abort_line_prev;
  logic src_done_prev;
  logic src_half_prev;
  logic dst_done_prev;
  logic dst_half_prev;
  logic cell_prev;
  logic block_prev;
  logic addr_err_prev;

  // Bus decode
  logic access;
  logic hit_event;
  logic hit_interrupt;
  logic mapped;
  logic write_event;
  logic write_interrupt;
  logic [31:0] read_value;

  // Bus timing seen from this slave, edge by edge:
  //   setup edge: nothing happens
  //   first access edge: the answer is armed
  //   next edge: pready, pslverr and prdata have stood one cycle and a
  //   write commits; the master sees exactly one wait state
  // Limitation: ce low freezes the answer too, so the clock enable must
  // stay high while a transfer is in its access phase
  assign access          = psel && penable && (apb_state == apb_answer);
  assign hit_event       = (paddr == event_control_offset);
  assign hit_interrupt   = (paddr == interrupt_control_offset);
  assign mapped          = hit_event || hit_interrupt;
  assign write_event     = access && pwrite && hit_event;
  assign write_interrupt = access && pwrite && hit_interrupt;

  // Answer sequencer: idle on setup and first access, answer on the next.
  // One wait state was traded for a registered pready, which keeps the
  // slave outputs glitch free at the cost of a cycle per transfer
  always_comb
  begin
    next_apb_state = apb_idle;
    case (apb_state)
      apb_idle:
        next_apb_state = (psel && penable) ? apb_answer : apb_idle;
      apb_answer:
        next_apb_state = apb_idle;
      default:
        next_apb_state = apb_idle;
    endcase
  end

  // Read words per register; force and abort are strobes and read zero
  logic [31:0] event_read_word;
  logic [31:0] interrupt_read_word;
  assign event_read_word     = {8'h00, abort_request_select,
                                start_request_select, 2'b00,
                                pattern_abort_enable, start_request_enable,
                                abort_request_enable, 3'b000};
  assign interrupt_read_word = {8'h00, fb.enables, 8'h00, fb.flags};

  // Read mux; an unmapped address reads zero alongside pslverr
  assign read_value = hit_event     ? event_read_word :
                      hit_interrupt ? interrupt_read_word :
                                      32'h0000_0000;

  // Selected interrupt lines. An occurrence is a rising edge, so a
  // source that holds its line high must drop it before it can start
  // or abort again. Hazard: rewriting a selector while the newly picked
  // line is already high looks like an edge and fires once; software
  // should clear the enable bit before it moves a selector.
  logic start_line;
  logic abort_line;
  logic start_hit;
  logic abort_hit;
  logic force_hit;
  logic soft_abort_hit;
  logic pattern_abort_hit;
  assign start_line = irq_lines[start_request_select];
  assign abort_line = irq_lines[abort_request_select];
  assign start_hit  = start_line && !start_line_prev &&
                      start_request_enable;
  assign abort_hit  = abort_line && !abort_line_prev &&
                      abort_request_enable;
  assign force_hit  = write_event && pstrb[0] &&
                      pwdata[force_transfer_bit];
  assign soft_abort_hit = write_event && pstrb[0] &&
                          pwdata[software_abort_bit];
  assign pattern_abort_hit = pattern_match && pattern_abort_enable;

  // Pointer arrival compares, taken as rising edges so each sets once.
  // Limitation: these are equality tests, so a pointer that steps over
  // its target without landing on it sets nothing; the counters must
  // advance in steps that meet the size and its half.
  logic src_done_now;
  logic src_half_now;
  logic dst_done_now;
  logic dst_half_now;
  logic cell_now;
  logic block_now;
  logic [size_width-1:0] larger_size;
  assign src_done_now = (source_pointer == source_size);
  assign src_half_now = (source_pointer == (source_size >> 1));
  assign dst_done_now = (dest_pointer == dest_size);
  assign dst_half_now = (dest_pointer == (dest_size >> 1));
  assign cell_now     = (cell_count == cell_size);
  assign larger_size  = (source_size > dest_size) ? source_size : dest_size;
  assign block_now    = (block_count == larger_size);

  // Flag set events toward the bank
  logic [flag_count-1:0] set_event;
  always_comb
  begin
    // Nothing is set unless its cause is seen in this cycle
    set_event = 8'h00;
    set_event[source_done_pos]    = src_done_now && !src_done_prev;
    set_event[source_half_pos]    = src_half_now && !src_half_prev;
    set_event[dest_done_pos]      = dst_done_now && !dst_done_prev;
    set_event[dest_half_pos]      = dst_half_now && !dst_half_prev;
    set_event[block_complete_pos] = (block_now && !block_prev) ||
                                    pattern_abort_hit;
    set_event[cell_complete_pos]  = cell_now && !cell_prev;
    set_event[transfer_abort_pos] = abort_hit;
    set_event[address_error_pos]  = address_invalid &&
                                    !addr_err_prev;
  end

  // Set events are masked while ce is low so a frozen cycle cannot set
  // a flag; clears come from byte 0 of a committed write and lose to a
  // set in the same cycle inside the bank
  assign fb.set_event    = ce ? set_event : 8'h00;
  assign fb.clear_mask   = (write_interrupt && pstrb[0]) ? pwdata[7:0]
                                                         : 8'h00;
  assign fb.enable_write = pwdata[enable_msb:enable_lsb];
  assign fb.enable_load  = write_interrupt && pstrb[2];

  // Event control register; each byte lane is written only when its
  // strobe is high, so software may move one selector on its own.
  // The two strobes in byte 0 are not stored: they act at the commit
  // edge and are gone by the next read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      abort_request_select <= select_reset;
      start_request_select <= select_reset;
      pattern_abort_enable <= 1'b0;
      start_request_enable <= 1'b0;
      abort_request_enable <= 1'b0;
    end
    else if (ce && write_event)
    begin
      if (pstrb[2])
      begin
        abort_request_select <= pwdata[abort_select_msb:abort_select_lsb];
      end
      if (pstrb[1])
      begin
        start_request_select <= pwdata[start_select_msb:start_select_lsb];
      end
      if (pstrb[0])
      begin
        pattern_abort_enable <= pwdata[pattern_abort_bit];
        start_request_enable <= pwdata[start_enable_bit];
        abort_request_enable <= pwdata[abort_enable_bit];
      end
    end
  end

  // Edge history. Every detector resets to the idle level of its input,
  // low, so the release of reset cannot be taken for an edge; ce low
  // freezes the history, so a line that rises and falls while frozen is
  // never seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_line_prev <= 1'b0;
      abort_line_prev <= 1'b0;
      src_done_prev   <= 1'b0;
      src_half_prev   <= 1'b0;
      dst_done_prev   <= 1'b0;
      dst_half_prev   <= 1'b0;
      cell_prev       <= 1'b0;
      block_prev      <= 1'b0;
      addr_err_prev   <= 1'b0;
    end
    else if (ce)
    begin
      start_line_prev <= start_line;
      abort_line_prev <= abort_line;
      src_done_prev   <= src_done_now;
      src_half_prev   <= src_half_now;
      dst_done_prev   <= dst_done_now;
      dst_half_prev   <= dst_half_now;
      cell_prev       <= cell_now;
      block_prev      <= block_now;
      addr_err_prev   <= address_invalid;
    end
  end

  // Command causes gathered here; a pattern abort both aborts and turns
  // the channel off, while only the selected abort interrupt sets the
  // abort flag
  logic next_start_transfer;
  logic next_abort_transfer;
  logic next_channel_off;
  assign next_start_transfer = start_hit || force_hit;
  assign next_abort_transfer = abort_hit || soft_abort_hit ||
                               pattern_abort_hit;
  assign next_channel_off    = pattern_abort_hit;

  // Channel command flops; start pulses one cycle, abort and off stay high while an enabled pattern_match holds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_transfer <= 1'b0;
      abort_transfer <= 1'b0;
      channel_off    <= 1'b0;
    end
    else if (ce)
    begin
      start_transfer <= next_start_transfer;
      abort_transfer <= next_abort_transfer;
      channel_off    <= next_channel_off;
    end
  end

  // Answer values; prdata is zero outside a read answer so a stale word
  // never shows on the bus
  logic        answer_due;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  assign answer_due   = (next_apb_state == apb_answer);
  assign next_pslverr = answer_due && !mapped;
  assign next_prdata  = (answer_due && !pwrite) ? read_value
                                                : 32'h0000_0000;

  // APB slave; registered answer keeps outputs straight from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_state <= apb_idle;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      apb_state <= next_apb_state;
      pready    <= answer_due;
      pslverr   <= next_pslverr;
      prdata    <= next_prdata;
    end
  end

  // The request is already a flop inside the bank, so it leaves as is
  assign irq = fb.irq;

endmodule : dma_channel_event_irq

// ---- rtl/dma_event_pkg.sv ----
// Package: register map, field positions and reset values of the channel
package dma_event_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] event_control_offset     = 8'h00;
  localparam logic [7:0] interrupt_control_offset = 8'h04;
  localparam int         addr_width               = 8;

  // Event control fields
  localparam int abort_select_lsb   = 16;
  localparam int abort_select_msb   = 23;
  localparam int start_select_lsb   = 8;
  localparam int start_select_msb   = 15;
  localparam int force_transfer_bit = 7;
  localparam int software_abort_bit = 6;
  localparam int pattern_abort_bit  = 5;
  localparam int start_enable_bit   = 4;
  localparam int abort_enable_bit   = 3;

  // Interrupt control fields
  localparam int enable_lsb = 16;
  localparam int enable_msb = 23;
  localparam int flag_count = 8;

  // Flag positions inside the flag byte
  localparam int source_done_pos    = 7;
  localparam int source_half_pos    = 6;
  localparam int dest_done_pos      = 5;
  localparam int dest_half_pos      = 4;
  localparam int block_complete_pos = 3;
  localparam int cell_complete_pos  = 2;
  localparam int transfer_abort_pos = 1;
  localparam int address_error_pos  = 0;

  // Reset values
  localparam logic [7:0] select_reset = 8'hff;
  localparam logic [7:0] flag_reset   = 8'h00;
  localparam logic [7:0] enable_reset = 8'h00;

  // Widths
  localparam int irq_count  = 256;
  localparam int size_width = 16;

  // APB answer sequencing
  typedef enum logic [1:0]
  {
    apb_idle   = 2'b01,
    apb_answer = 2'b10
  } apb_state_t;

endpackage : dma_event_pkg

// ---- rtl/flag_bank.sv ----
// Module: sticky status flags, their enables and the interrupt request
module flag_bank
  import dma_event_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   ce,
  flag_bank_if.bank   fb
);

  logic [flag_count-1:0] flags;
  logic [flag_count-1:0] enables;
  logic                  irq;
  logic [flag_count-1:0] next_flags;
  logic                  next_irq;

  // Set wins over a write-one clear arriving in the same cycle
  assign next_flags = (flags & ~fb.clear_mask) | fb.set_event;
  // Interrupt follows the flags as they will stand after this edge
  assign next_irq   = |(next_flags & enables);

  // Flags and enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags   <= flag_reset;
      enables <= enable_reset;
      irq     <= 1'b0;
    end
    else if (ce)
    begin
      flags <= next_flags;
      irq   <= next_irq;
      if (fb.enable_load)
      begin
        enables <= fb.enable_write;
      end
    end
  end

  assign fb.flags   = flags;
  assign fb.enables = enables;
  assign fb.irq     = irq;

endmodule : flag_bank

// ---- rtl/flag_bank_if.sv ----
// Interface: sticky flag bank control and status between the channel modules
interface flag_bank_if;
  import dma_event_pkg::*;
  logic [flag_count-1:0] set_event;
  logic [flag_count-1:0] clear_mask;
  logic [flag_count-1:0] enable_write;
  logic                  enable_load;
  logic [flag_count-1:0] flags;
  logic [flag_count-1:0] enables;
  logic                  irq;

  modport owner
  (
    output set_event,
    output clear_mask,
    output enable_write,
    output enable_load,
    input  flags,
    input  enables,
    input  irq
  );

  modport bank
  (
    input  set_event,
    input  clear_mask,
    input  enable_write,
    input  enable_load,
    output flags,
    output enables,
    output irq
  );
endinterface : flag_bank_if

// ---- tb/dma_channel_event_irq_tb.sv ----
// Self-checking bench for the channel event and interrupt block
module dma_channel_event_irq_tb;
  import dma_event_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [addr_width-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, start_transfer, abort_transfer, channel_off, irq, e;
  logic [irq_count-1:0] irq_lines;
  logic pattern_match, address_invalid;
  logic [size_width-1:0] source_pointer, source_size, dest_pointer;
  logic [size_width-1:0] dest_size, cell_count, cell_size, block_count;
  int err_total = 0, check_count = 0, st_n = 0, ab_n = 0, off_n = 0;
  int seed = 5349, n;
  logic [7:0] asel, ssel;
  localparam logic [31:0] en_all = 32'h00ff0000;

  dma_channel_event_irq u_dma_channel_event_irq (.*);
  periph_model u_periph_model (.*);

  always #20 pclk = ~pclk;

  // Pulse counters see the value settled before each edge
  always @(posedge pclk)
  begin
    if (start_transfer === 1'b1) st_n++;
    if (abort_transfer === 1'b1) ab_n++;
    if (channel_off === 1'b1) off_n++;
  end

  function automatic logic [31:0] ec_word(logic [7:0] a, s, c);
    return {8'h00, a, s, c & 8'h38}; // Force and abort read as zero
  endfunction : ec_word

  task automatic chk(input logic [32:0] s, input logic [32:0] x);
    check_count++;
    if (s !== x)
    begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // One transfer: setup, access, hold until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16)
    begin
      err_total++;
      give_verdict();
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'b0, a, '0);
    chk({e, q}, x);
  endtask : rd

  task automatic ev(input int b, input int l);
    u_periph_model.fire(b, l);
    repeat (2) @(posedge pclk);
  endtask : ev

  task give_verdict;
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, ec_word(select_reset, select_reset, 8'h00));
    rd(8'h04, 33'h0);
    rd(8'h0c, 33'h100000000);
    n = $random(seed);
    ssel = n[7:0];
    asel = (n[15:8] == ssel) ? ~ssel : n[15:8];
    apb(1'b1, 8'h00, ec_word(asel, ssel, 8'h38) | 32'h80);
    repeat (3) @(posedge pclk);
    chk(33'(st_n), 33'd1);
    rd(8'h00, ec_word(asel, ssel, 8'h38));
    apb(1'b1, 8'h04, en_all);
    rd(8'h04, en_all);
    ev(1, ssel);
    chk(33'(st_n), 33'd2);
    ev(1, asel);
    chk(33'(ab_n), 33'd1);
    rd(8'h04, en_all | 32'h2);
    apb(1'b1, 8'h04, en_all | 32'h2);
    // Other lines toggling must start and abort nothing
    repeat (30)
    begin
      n = $random(seed);
      if (n[7:0] != ssel && n[7:0] != asel) ev(1, n[7:0]);
    end
    chk(33'(st_n + ab_n), 33'd3);
    apb(1'b1, 8'h00, ec_word(asel, ssel, 8'h20) | 32'h40);
    repeat (3) @(posedge pclk);
    chk(33'(ab_n), 33'd2);
    ev(1, ssel);
    ev(1, asel);
    chk(33'(st_n + ab_n), 33'd4);
    ev(8, 0);
    chk(33'(off_n), 33'd1);
    chk(33'(ab_n), 33'd3);
    rd(8'h04, en_all | 32'h8);
    apb(1'b1, 8'h04, en_all | 32'h8);
    apb(1'b1, 8'h00, ec_word(asel, ssel, 8'h18));
    ev(8, 0);
    chk(33'(off_n), 33'd1);
    rd(8'h04, en_all);
    // Frozen by ce: a line pulse that is never sampled starts nothing
    ce <= 1'b0;
    ev(1, ssel);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(33'(st_n), 33'd2);
    // Byte lanes: only the start selector moves, both strobes ignored
    pstrb <= 4'h2;
    apb(1'b1, 8'h00, ec_word(asel, ~ssel, 8'h00) | 32'hc0);
    pstrb <= 4'hf;
    rd(8'h00, ec_word(asel, ~ssel, 8'h18));
    repeat (2) @(posedge pclk);
    chk(33'(st_n + ab_n), 33'd5);
    // Every flag cause in turn, seen on the interrupt, then cleared
    for (int b = 7; b >= 0; b--)
    begin
      ev(b, asel);
      chk(33'(irq), 33'd1);
      rd(8'h04, en_all | (32'h1 << b));
      apb(1'b1, 8'h04, en_all | (32'h1 << b));
      rd(8'h04, en_all);
      chk(33'(irq), 33'd0);
    end
    apb(1'b1, 8'h04, 32'h0);
    ev(7, 0);
    chk(33'(irq), 33'd0);
    apb(1'b1, 8'h04, 32'h00800000);
    repeat (2) @(posedge pclk);
    chk(33'(irq), 33'd1);
    give_verdict();
  end
endmodule : dma_channel_event_irq_tb

bind dma_channel_event_irq dma_event_monitor u_dma_event_monitor (.*);

// ---- tb/dma_event_monitor.sv ----
// Checker for the channel event and interrupt block, bound to its top
module dma_event_monitor
  import dma_event_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [irq_count-1:0]  irq_lines,
  input wire logic                  pattern_match,
  input wire logic                  start_transfer,
  input wire logic                  abort_transfer,
  input wire logic                  channel_off,
  input wire logic                  irq
);
  logic [7:0] asel, ssel, ie;
  logic [2:0] ctl; // Pattern, start and abort enables
  wire wr  = psel && penable && pready && pwrite && !pslverr;
  wire wec = wr && paddr == event_control_offset && pstrb[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow fields move at the same commit edge as the design's registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      asel <= select_reset;
      ssel <= select_reset;
      ie   <= enable_reset;
      ctl  <= 3'h0;
    end
    else if (wr && paddr == event_control_offset)
    begin
      if (pstrb[0]) ctl <= pwdata[5:3];
      if (pstrb[1]) ssel <= pwdata[15:8];
      if (pstrb[2]) asel <= pwdata[23:16];
    end
    else if (wr && paddr == interrupt_control_offset && pstrb[2])
      ie <= pwdata[23:16];

  start_irq_a:
    assert property (ce && $past(ce) && ctl[1] && irq_lines[ssel]
      && !$past(irq_lines[ssel]) |=> start_transfer)
      else $error("start event not answered");
  abort_irq_a:
    assert property (ce && $past(ce) && ctl[0] && irq_lines[asel]
      && !$past(irq_lines[asel]) |=> abort_transfer)
      else $error("abort event not answered");
  force_start_a:
    assert property (wec && pwdata[7] |-> ##[1:2] start_transfer)
      else $error("forced start missing");
  soft_abort_a:
    assert property (wec && pwdata[6] |-> ##[1:2] abort_transfer)
      else $error("software abort missing");
  pattern_off_a:
    assert property (ctl[2] && $rose(pattern_match) |=> channel_off)
      else $error("pattern match did not stop channel");
  pattern_idle_a:
    assert property (!ctl[2] && !$past(ctl[2]) && pattern_match
      |=> !channel_off) else $error("disabled pattern stopped channel");
  irq_masked_a:
    assert property (ie == 8'h00 && $past(ie) == 8'h00 |-> !irq)
      else $error("interrupt with all enables clear");
  read_zero_a:
    assert property (pready && !pwrite && paddr == event_control_offset
      |-> prdata[7:6] == 2'h0 && prdata[31:24] == 8'h00)
      else $error("write-only bits read back set");
  unmapped_err_a:
    assert property (pready && paddr != event_control_offset
      && paddr != interrupt_control_offset |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");
  one_wait_a:
    assert property (psel && $rose(penable) |=> pready)
      else $error("bus answer late");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held");

  cover property (start_transfer);
  cover property (abort_transfer);
  cover property (channel_off);
  cover property (irq);
endmodule : dma_event_monitor

// ---- tb/periph_model.sv ----
// Model of the peripheral event sources and transfer counters
module periph_model
  import dma_event_pkg::*;
(
  input  wire logic                  pclk,
  output logic      [irq_count-1:0]  irq_lines,
  output logic                       pattern_match,
  output logic                       address_invalid,
  output logic      [size_width-1:0] source_pointer,
  output logic      [size_width-1:0] source_size,
  output logic      [size_width-1:0] dest_pointer,
  output logic      [size_width-1:0] dest_size,
  output logic      [size_width-1:0] cell_count,
  output logic      [size_width-1:0] cell_size,
  output logic      [size_width-1:0] block_count
);
  localparam logic [15:0] buf_len  = 16'h0040;
  localparam logic [15:0] cell_len = 16'h0008;
  // Shorter destination, so block completion must follow the source size
  localparam logic [15:0] dest_len = 16'h0020;

  // Idle values match no compare, so nothing fires before a scenario
  task automatic quiet;
    irq_lines       <= '0;
    pattern_match   <= 1'b0;
    address_invalid <= 1'b0;
    source_pointer  <= 16'h0001;
    dest_pointer    <= 16'h0001;
    cell_count      <= 16'h0001;
    block_count     <= 16'h0001;
  endtask : quiet

  initial
  begin
    source_size = buf_len;
    dest_size   = dest_len;
    cell_size   = cell_len;
    quiet();
  end

  // One event for a single cycle: flag cause b, or interrupt line n
  task automatic fire(input int b, input int n);
    case (b)
      7: source_pointer <= buf_len;
      6: source_pointer <= buf_len >> 1;
      5: dest_pointer <= dest_len;
      4: dest_pointer <= dest_len >> 1;
      3: block_count <= buf_len;
      2: cell_count <= cell_len;
      1: irq_lines[n] <= 1'b1;
      0: address_invalid <= 1'b1;
      default: pattern_match <= 1'b1;
    endcase
    @(posedge pclk);
    quiet();
  endtask : fire
endmodule : periph_model
